/* common/cbi_pkg.sv */
// Purpose: Shared constants for the connection memory block fill
// Assumes: 40 MHz reference clock, byte-addressed 32-bit register port
// Notes:   Register offsets are byte addresses of aligned words
package cbi_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 20;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_FILL_PATTERN        = 20'h40288;
  localparam logic [ADDR_W-1:0] OFF_FILL_TRIGGER_STATUS = 20'h4028c;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS          = 20'h40290;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR           = 20'h40294;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE          = 20'h40298;

  // ----------------------------------------------------------------
  // Reset values and key
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_FILL_PATTERN = 32'h00000000;
  localparam logic [DATA_W-1:0] FILL_KEY         = 32'h31415926;
  localparam logic [DATA_W-1:0] READ_ZERO        = 32'h00000000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int STAT_FILL_BIT = 0;
  localparam int STAT_PWR_BIT  = 1;
  localparam int STAT_W        = 2;

  // Interrupt event bits
  localparam int IRQ_FILL_DONE  = 0;
  localparam int IRQ_PWR_DONE   = 1;
  localparam int IRQ_ACC_FAULT  = 2;
  localparam int IRQ_TRIG_IGNORE = 3;
  localparam int IRQ_W          = 4;
  localparam logic [IRQ_W-1:0] RST_IRQ = 4'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 25;
  localparam int FILL_TIME_US   = 120;
  localparam int NS_PER_US      = 1000;
  // Longest time, rounded down to whole cycles
  localparam int FILL_MAX_CYCLES_DEF = (FILL_TIME_US * NS_PER_US) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Memory geometry defaults
  // ----------------------------------------------------------------
  localparam int CM_DEPTH_DEF = 32768;
  localparam int CM_LANES_DEF = 8;

  // Fill engine states
  typedef enum logic [0:0] {
    CBI_IDLE,
    CBI_FILL
  } cbi_state_t;

endpackage

/* src/cbi_fill_engine.sv */
// Purpose: Walks every connection memory row and writes the fill pattern
// Assumes: Each row holds LANES words, all written in one cycle
// Notes:   Pattern is captured at start and held for the whole fill
`timescale 1ns/100ps
module cbi_fill_engine #(
  parameter int ROWS  = 4096,
  parameter int ROW_W = 12
) (
  // Clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     sys_rst,
  // Control
  input  wire logic                     start,
  input  wire logic [cbi_pkg::DATA_W-1:0] pattern,
  output logic                          busy,
  output logic                          done,
  // Memory write side
  output logic [ROW_W-1:0]              row,
  output logic [cbi_pkg::DATA_W-1:0]    word
);

  cbi_pkg::cbi_state_t state_reg;
  cbi_pkg::cbi_state_t state_next;
  logic [ROW_W-1:0]           row_reg;
  logic [ROW_W-1:0]           row_next;
  logic [cbi_pkg::DATA_W-1:0] pat_reg;
  logic [cbi_pkg::DATA_W-1:0] pat_next;
  logic                       done_reg;
  logic                       done_next;

  localparam logic [ROW_W-1:0] LAST_ROW = ROW_W'(ROWS - 1);
  localparam logic [ROW_W-1:0] ROW_ONE  = ROW_W'(1);
  localparam logic [ROW_W-1:0] ROW_ZERO = ROW_W'(0);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    row_next   = row_reg;
    pat_next   = pat_reg;
    done_next  = 1'b0;
    case (state_reg)
      cbi_pkg::CBI_IDLE: begin
        if (start) begin
          state_next = cbi_pkg::CBI_FILL;
          row_next   = ROW_ZERO;
          pat_next   = pattern;
        end
      end
      cbi_pkg::CBI_FILL: begin
        if (row_reg == LAST_ROW) begin
          state_next = cbi_pkg::CBI_IDLE;
          done_next  = 1'b1;
        end else begin
          row_next = row_reg + ROW_ONE;
        end
      end
      default: begin
        state_next = cbi_pkg::CBI_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= cbi_pkg::CBI_IDLE;
      row_reg   <= ROW_ZERO;
      pat_reg   <= cbi_pkg::RST_FILL_PATTERN;
      done_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      row_reg   <= row_next;
      pat_reg   <= pat_next;
      done_reg  <= done_next;
    end
  end

  assign busy = (state_reg == cbi_pkg::CBI_FILL);
  assign done = done_reg;
  assign row  = row_reg;
  assign word = pat_reg;

endmodule

/* src/cbi_block_init.sv */
// Purpose: Connection memory block fill with pattern, trigger and status
// Assumes: Register port with one-cycle strobes, read data one cycle later
// Notes:   Fill also starts by itself after reset; memory access is refused
//          and TDM outputs are held off while any fill runs
//
// Local design decision: the strobed register port.
`timescale 1ns/100ps
module cbi_block_init #(
  parameter int CM_DEPTH        = cbi_pkg::CM_DEPTH_DEF,
  parameter int CM_LANES        = cbi_pkg::CM_LANES_DEF,
  parameter int FILL_MAX_CYCLES = cbi_pkg::FILL_MAX_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         sys_rst,
  // Register port
  input  wire logic [cbi_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [cbi_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [cbi_pkg::DATA_W-1:0]   reg_rdata,
  // Host access to connection or data memory
  input  wire logic                         mem_acc_req,
  output logic                              mem_acc_grant,
  output logic                              access_fault_flag,
  // Connection memory fill write port
  output logic                              cm_fill_we,
  output logic      [$clog2(CM_DEPTH/CM_LANES)-1:0] cm_fill_row,
  output logic      [cbi_pkg::DATA_W-1:0]   cm_fill_data,
  // TDM output control
  output logic                              tdm_out_hiz,
  // Interrupt
  output logic                              irq
);

  // ----------------------------------------------------------------
  // Geometry and elaboration checks
  // ----------------------------------------------------------------
  localparam int ROWS  = CM_DEPTH / CM_LANES;
  localparam int ROW_W = $clog2(ROWS);

  if (CM_LANES < 1 || CM_DEPTH % CM_LANES != 0) begin : g_bad_lanes
    $error("CM_DEPTH must be a multiple of CM_LANES");
  end
  if (ROWS < 2) begin : g_bad_rows
    $error("Fill needs at least two rows");
  end
  // A full fill must fit within the allowed fill time
  if (ROWS > FILL_MAX_CYCLES) begin : g_bad_time
    $error("Fill cannot complete in the allowed time");
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [cbi_pkg::ADDR_W-1:0] addr,
                               input logic [cbi_pkg::ADDR_W-1:0] off);
    hit = (addr == off);
  endfunction

  wire sel_pattern = hit(reg_addr, cbi_pkg::OFF_FILL_PATTERN);
  wire sel_trigger = hit(reg_addr, cbi_pkg::OFF_FILL_TRIGGER_STATUS);
  wire sel_irq_st  = hit(reg_addr, cbi_pkg::OFF_IRQ_STATUS);
  wire sel_irq_clr = hit(reg_addr, cbi_pkg::OFF_IRQ_CLEAR);
  wire sel_irq_en  = hit(reg_addr, cbi_pkg::OFF_IRQ_ENABLE);

  wire wr_pattern = reg_wr && sel_pattern;
  wire wr_trigger = reg_wr && sel_trigger;
  wire wr_irq_clr = reg_wr && sel_irq_clr;
  wire wr_irq_en  = reg_wr && sel_irq_en;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [cbi_pkg::DATA_W-1:0] pattern_reg;
  logic [cbi_pkg::DATA_W-1:0] pattern_next;
  logic                       pwr_pend_reg;
  logic                       pwr_pend_next;
  logic                       pwr_init_reg;
  logic                       pwr_init_next;
  logic                       hiz_reg;
  logic                       hiz_next;
  logic                       fault_reg;
  logic                       fault_next;
  logic                       grant_reg;
  logic                       grant_next;
  logic [cbi_pkg::DATA_W-1:0] rdata_reg;
  logic [cbi_pkg::DATA_W-1:0] rdata_next;
  logic [cbi_pkg::IRQ_W-1:0]  irq_st_reg;
  logic [cbi_pkg::IRQ_W-1:0]  irq_st_next;
  logic [cbi_pkg::IRQ_W-1:0]  irq_en_reg;
  logic [cbi_pkg::IRQ_W-1:0]  irq_en_next;
  logic                       irq_reg;
  logic                       irq_next;

  wire                        fill_busy;
  wire                        fill_done;
  wire [ROW_W-1:0]            fill_row;
  wire [cbi_pkg::DATA_W-1:0]  fill_word;

  // ----------------------------------------------------------------
  // Pattern register
  // ----------------------------------------------------------------
  // The engine keeps its own copy, so a write here never disturbs a fill
  assign pattern_next = wr_pattern ? reg_wdata : pattern_reg;

  // ----------------------------------------------------------------
  // Fill start
  // ----------------------------------------------------------------
  wire key_match   = (reg_wdata == cbi_pkg::FILL_KEY);
  wire key_write   = wr_trigger && key_match;
  // Any non-key value falls through here and changes nothing
  wire any_fill    = fill_busy || pwr_pend_reg;
  wire sw_start    = key_write && !any_fill;
  wire trig_ignore = key_write && any_fill;
  wire fill_start  = pwr_pend_reg || sw_start;

  // Pending flag is high for the first cycle after reset only
  assign pwr_pend_next = 1'b0;

  // Power-up status stays up until the first fill ends
  assign pwr_init_next = pwr_init_reg && !fill_done;

  // ----------------------------------------------------------------
  // Fill engine
  // ----------------------------------------------------------------
  cbi_fill_engine #(
    .ROWS  (ROWS),
    .ROW_W (ROW_W)
  ) u_engine (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .start   (fill_start),
    .pattern (pattern_reg),
    .busy    (fill_busy),
    .done    (fill_done),
    .row     (fill_row),
    .word    (fill_word)
  );

  // ----------------------------------------------------------------
  // TDM output hold-off
  // ----------------------------------------------------------------
  // Raised with the start request so outputs float from the first row on
  assign hiz_next = fill_start || (fill_busy && !fill_done);

  // ----------------------------------------------------------------
  // Memory access gate
  // ----------------------------------------------------------------
  wire mem_block = any_fill || fill_busy || pwr_init_reg;
  assign fault_next = mem_acc_req && mem_block;
  assign grant_next = mem_acc_req && !mem_block;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  wire [cbi_pkg::STAT_W-1:0] init_status;
  assign init_status[cbi_pkg::STAT_FILL_BIT] = fill_busy || pwr_pend_reg;
  assign init_status[cbi_pkg::STAT_PWR_BIT]  = pwr_init_reg;

  // Trigger reads show status only; upper bits are zero
  wire [cbi_pkg::DATA_W-1:0] trig_rd =
    {{(cbi_pkg::DATA_W-cbi_pkg::STAT_W){1'b0}}, init_status};
  wire [cbi_pkg::DATA_W-1:0] irq_st_rd =
    {{(cbi_pkg::DATA_W-cbi_pkg::IRQ_W){1'b0}}, irq_st_reg};
  wire [cbi_pkg::DATA_W-1:0] irq_en_rd =
    {{(cbi_pkg::DATA_W-cbi_pkg::IRQ_W){1'b0}}, irq_en_reg};

  // Clear register is write-only and reads as zero like unmapped space
  wire [cbi_pkg::DATA_W-1:0] rd_mux =
    sel_pattern ? pattern_reg :
    sel_trigger ? trig_rd     :
    sel_irq_st  ? irq_st_rd   :
    sel_irq_en  ? irq_en_rd   :
                  cbi_pkg::READ_ZERO;

  assign rdata_next = reg_rd ? rd_mux : cbi_pkg::READ_ZERO;

  // ----------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------
  wire [cbi_pkg::IRQ_W-1:0] irq_evt;
  assign irq_evt[cbi_pkg::IRQ_FILL_DONE]   = fill_done;
  assign irq_evt[cbi_pkg::IRQ_PWR_DONE]    = fill_done && pwr_init_reg;
  assign irq_evt[cbi_pkg::IRQ_ACC_FAULT]   = fault_next;
  assign irq_evt[cbi_pkg::IRQ_TRIG_IGNORE] = trig_ignore;

  wire [cbi_pkg::IRQ_W-1:0] irq_clr = wr_irq_clr ? reg_wdata[cbi_pkg::IRQ_W-1:0] : cbi_pkg::RST_IRQ;

  // Sticky bits: a new event wins over a clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < cbi_pkg::IRQ_W; gi = gi + 1) begin : g_irq
      assign irq_st_next[gi] = irq_evt[gi] || (irq_st_reg[gi] && !irq_clr[gi]);
    end
  endgenerate

  assign irq_en_next = wr_irq_en ? reg_wdata[cbi_pkg::IRQ_W-1:0] : irq_en_reg;
  assign irq_next    = |(irq_st_next & irq_en_next);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pattern_reg <= cbi_pkg::RST_FILL_PATTERN;
      pwr_pend_reg <= 1'b1;
      pwr_init_reg <= 1'b1;
    end else begin
      pattern_reg  <= pattern_next;
      pwr_pend_reg <= pwr_pend_next;
      pwr_init_reg <= pwr_init_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hiz_reg   <= 1'b1;
      fault_reg <= 1'b0;
      grant_reg <= 1'b0;
      rdata_reg <= cbi_pkg::READ_ZERO;
    end else begin
      hiz_reg   <= hiz_next;
      fault_reg <= fault_next;
      grant_reg <= grant_next;
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_st_reg <= cbi_pkg::RST_IRQ;
      irq_en_reg <= cbi_pkg::RST_IRQ;
      irq_reg    <= 1'b0;
    end else begin
      irq_st_reg <= irq_st_next;
      irq_en_reg <= irq_en_next;
      irq_reg    <= irq_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata         = rdata_reg;
  assign mem_acc_grant     = grant_reg;
  assign access_fault_flag = fault_reg;
  assign cm_fill_we        = fill_busy;
  assign cm_fill_row       = fill_row;
  assign cm_fill_data      = fill_word;
  assign tdm_out_hiz       = hiz_reg;
  assign irq               = irq_reg;

endmodule

/* testbench/cbi_block_init_sva.sv */
// Purpose: Port checks for the connection memory block fill
// Assumes: Synchronous active-high reset on ref_clk
// Notes:   Bound to every cbi_block_init instance
`timescale 1ns/100ps
module cbi_block_init_sva #(
  parameter int CM_DEPTH = 64,
  parameter int CM_LANES = 8
) (
  // Clock and reset
  input wire logic                                 ref_clk,
  input wire logic                                 sys_rst,
  // Register port
  input wire logic [cbi_pkg::ADDR_W-1:0]           reg_addr,
  input wire logic [cbi_pkg::DATA_W-1:0]           reg_wdata,
  input wire logic                                 reg_wr,
  input wire logic                                 reg_rd,
  input wire logic [cbi_pkg::DATA_W-1:0]           reg_rdata,
  // Memory access and fill port
  input wire logic                                 mem_acc_req,
  input wire logic                                 mem_acc_grant,
  input wire logic                                 access_fault_flag,
  input wire logic                                 cm_fill_we,
  input wire logic [$clog2(CM_DEPTH/CM_LANES)-1:0] cm_fill_row,
  input wire logic [cbi_pkg::DATA_W-1:0]           cm_fill_data,
  input wire logic                                 tdm_out_hiz
);
  localparam int ROWS = CM_DEPTH / CM_LANES;
  logic [31:0] run_cnt;
  wire         trig_sel = reg_addr == cbi_pkg::OFF_FILL_TRIGGER_STATUS;
  wire         key_wr   = reg_wr && trig_sel && reg_wdata == cbi_pkg::FILL_KEY;
  wire         idle     = !tdm_out_hiz && !cm_fill_we;

  // Length of the current run of fill writes
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      run_cnt <= 32'h0;
    end else if (cm_fill_we) begin
      run_cnt <= run_cnt + 32'h1;
    end else begin
      run_cnt <= 32'h0;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  fill_len_a: assert property ($fell(cm_fill_we) |-> run_cnt == ROWS)
    else $error("fill run length wrong");
  row_first_a: assert property ($rose(cm_fill_we) |-> cm_fill_row == '0)
    else $error("fill does not begin at row zero");
  row_step_a: assert property (cm_fill_we && $past(cm_fill_we) |-> cm_fill_row == $past(cm_fill_row) + 1'b1)
    else $error("fill row not incremented");
  data_hold_a: assert property (cm_fill_we && $past(cm_fill_we) |-> $stable(cm_fill_data))
    else $error("fill word changed mid fill");
  hiz_fill_a: assert property (cm_fill_we |-> tdm_out_hiz)
    else $error("outputs driven during fill");
  key_start_a: assert property (key_wr && idle |=> cm_fill_we throughout (tdm_out_hiz [*8]))
    else $error("key write did not start fill");
  nokey_idle_a: assert property (reg_wr && trig_sel && !key_wr && idle |=> !cm_fill_we ##1 !cm_fill_we)
    else $error("non key write started fill");
  fault_busy_a: assert property (mem_acc_req && cm_fill_we |=> access_fault_flag && !mem_acc_grant)
    else $error("access during fill not faulted");
  grant_idle_a: assert property (mem_acc_req && idle && !reg_wr |=> mem_acc_grant && !access_fault_flag)
    else $error("idle access not granted");
  stat_busy_a: assert property (reg_rd && trig_sel && cm_fill_we |=> reg_rdata[0] && reg_rdata[31:2] == '0)
    else $error("status busy bit wrong");
  stat_idle_a: assert property (reg_rd && trig_sel && idle |=> reg_rdata == cbi_pkg::READ_ZERO)
    else $error("idle status not zero");
  hiz_drop_a: assert property ($fell(cm_fill_we) && !reg_wr |=> !tdm_out_hiz)
    else $error("outputs held off after fill");
endmodule

bind cbi_block_init cbi_block_init_sva #(.CM_DEPTH(CM_DEPTH), .CM_LANES(CM_LANES)) i_sva (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_acc_req(mem_acc_req),
  .mem_acc_grant(mem_acc_grant), .access_fault_flag(access_fault_flag), .cm_fill_we(cm_fill_we),
  .cm_fill_row(cm_fill_row), .cm_fill_data(cm_fill_data), .tdm_out_hiz(tdm_out_hiz));

/* testbench/cbi_cm_model.sv */
// Purpose: Connection memory seen by the fill write port
// Assumes: One row written per cycle while the write enable is high
// Notes:   Rows start unknown, so a missed row never reads as a match
`timescale 1ns/100ps
module cbi_cm_model #(
  parameter int ROWS = 16
) (
  // Clock
  input wire logic                        ref_clk,
  // Fill write port
  input wire logic                        cm_fill_we,
  input wire logic [$clog2(ROWS)-1:0]     cm_fill_row,
  input wire logic [cbi_pkg::DATA_W-1:0]  cm_fill_data
);
  logic [cbi_pkg::DATA_W-1:0] mem [ROWS];
  int                         wr_count = 0;

  always @(posedge ref_clk) begin
    if (cm_fill_we === 1'b1) begin
      mem[cm_fill_row] <= cm_fill_data;
      wr_count <= wr_count + 1;
    end
  end
endmodule

/* testbench/cbi_block_init_test.sv */
// Purpose: Self-checking bench for the connection memory block fill
// Assumes: 16-row memory so each fill lasts 16 cycles
// Notes:   Expected values come from the package constants, random patterns and literal IRQ words
`timescale 1ns/100ps
module cbi_block_init_test;
  localparam int ROWS = 16;
  localparam logic [19:0] PAT = cbi_pkg::OFF_FILL_PATTERN;
  localparam logic [19:0] TRG = cbi_pkg::OFF_FILL_TRIGGER_STATUS;
  localparam logic [31:0] KEY = cbi_pkg::FILL_KEY;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [19:0] reg_addr = 20'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic mem_acc_req = 1'b0;
  logic [31:0] reg_rdata;
  logic mem_acc_grant, access_fault_flag, cm_fill_we, tdm_out_hiz, irq;
  logic [3:0] cm_fill_row;
  logic [31:0] cm_fill_data;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #12.5 ref_clk = ~ref_clk;

  cbi_block_init #(.CM_DEPTH(128), .CM_LANES(8), .FILL_MAX_CYCLES(ROWS)) i_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_acc_req(mem_acc_req),
    .mem_acc_grant(mem_acc_grant), .access_fault_flag(access_fault_flag), .cm_fill_we(cm_fill_we),
    .cm_fill_row(cm_fill_row), .cm_fill_data(cm_fill_data), .tdm_out_hiz(tdm_out_hiz), .irq(irq));
  cbi_cm_model #(.ROWS(ROWS)) i_mem (
    .ref_clk(ref_clk), .cm_fill_we(cm_fill_we), .cm_fill_row(cm_fill_row), .cm_fill_data(cm_fill_data));

  // ----------------------------------------------------------------
  // Compare and bus tasks
  // ----------------------------------------------------------------
  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask
  // Trigger readback: fill bit and power-up bit, all else zero
  function automatic logic [31:0] exp_stat(input logic fill, input logic pwr);
    exp_stat = cbi_pkg::READ_ZERO;
    exp_stat[cbi_pkg::STAT_FILL_BIT] = fill;
    exp_stat[cbi_pkg::STAT_PWR_BIT]  = pwr;
  endfunction
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [19:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk32("reg_rdata", e, reg_rdata);
  endtask
  task automatic acc(input logic fault);
    @(posedge ref_clk);
    mem_acc_req <= 1'b1;
    @(posedge ref_clk);
    mem_acc_req <= 1'b0;
    #1 chk1("access_fault_flag", fault, access_fault_flag);
    chk1("mem_acc_grant", !fault, mem_acc_grant);
  endtask
  task automatic irq_chk(input logic e);
    @(posedge ref_clk);
    #1 chk1("irq", e, irq);
  endtask
  task automatic fill_chk(input logic [31:0] p, input int c0);
    int n;
    n = 0;
    // Let a start taken at this very edge reach the hold-off output first
    #1;
    while (tdm_out_hiz !== 1'b0 && n < 100) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk1("tdm_out_hiz", 1'b0, tdm_out_hiz);
    chk32("row writes", ROWS, i_mem.wr_count - c0);
    for (int r = 0; r < ROWS; r++) chk32("cm row", p, i_mem.mem[r]);
  endtask
  task automatic complete_run;
    if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] p1, d;
    int c0;
    void'($urandom(80));
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd_chk(TRG, exp_stat(1'b1, 1'b1));
    acc(1'b1);
    fill_chk(32'h0, 0);
    rd_chk(TRG, exp_stat(1'b0, 1'b0));
    rd_chk(PAT, cbi_pkg::RST_FILL_PATTERN);
    acc(1'b0);
    p1 = $urandom;
    wr(PAT, p1);
    rd_chk(PAT, p1);
    c0 = i_mem.wr_count;
    wr(TRG, KEY);
    wr(PAT, ~p1);
    wr(TRG, KEY);
    rd_chk(TRG, exp_stat(1'b1, 1'b0));
    acc(1'b1);
    fill_chk(p1, c0);
    rd_chk(PAT, ~p1);
    for (int i = 0; i < 4; i++) begin
      d = (i == 0) ? KEY + 32'h1 : (i == 1) ? 32'h0 : $urandom;
      if (d == KEY) d = 32'h0;
      wr(TRG, d);
      irq_chk(1'b0);
      chk1("cm_fill_we", 1'b0, cm_fill_we);
    end
    rd_chk(TRG, exp_stat(1'b0, 1'b0));
    rd_chk(cbi_pkg::OFF_IRQ_ENABLE, 32'h0);
    rd_chk(cbi_pkg::OFF_IRQ_STATUS, 32'hf);
    wr(cbi_pkg::OFF_IRQ_ENABLE, 32'h1);
    irq_chk(1'b1);
    wr(cbi_pkg::OFF_IRQ_CLEAR, 32'h1);
    irq_chk(1'b0);
    rd_chk(cbi_pkg::OFF_IRQ_STATUS, 32'he);
    rd_chk(cbi_pkg::OFF_IRQ_CLEAR, 32'h0);
    rd_chk(20'h40300, 32'h0);
    wr(cbi_pkg::OFF_IRQ_ENABLE, 32'hf);
    irq_chk(1'b1);
    wr(cbi_pkg::OFF_IRQ_CLEAR, 32'hf);
    irq_chk(1'b0);
    for (int i = 0; i < 3; i++) begin
      p1 = $urandom;
      wr(PAT, p1);
      c0 = i_mem.wr_count;
      wr(TRG, KEY);
      fill_chk(p1, c0);
    end
    wr(TRG, KEY);
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    c0 = i_mem.wr_count;
    rd_chk(TRG, exp_stat(1'b1, 1'b1));
    fill_chk(32'h0, c0);
    complete_run();
  end
endmodule
